/* File: logic/strap_cfg_pkg.sv */
// package: strap codes, configuration record, register map, port map types
// assumes one 50 MHz clock; strap levels arrive already resolved to 2-bit codes
package strap_cfg_pkg;
   // strap mode code: 2'h0 = mode 1 ... 2'h3 = mode 4
   typedef logic [1:0] strap_mode_t;

   typedef struct packed {
      strap_mode_t addr_low;    // addr_low_strap_pin
      strap_mode_t addr_high;   // addr_high_strap_pin
      strap_mode_t rx_ctrl;     // autoneg-disable strap
      strap_mode_t gp0;         // rx skew bit 0 strap
      strap_mode_t gp1;         // rx skew bits 2:1 strap
      strap_mode_t tx_skew;     // tx_skew_strap_pin
      strap_mode_t mirror_if;   // mirror_iface_strap_pin
   } strap_pins_t;

   typedef struct packed {
      logic [3:0] mgmt_addr;
      logic       aneg_dis;
      logic [2:0] rx_skew;
      logic [1:0] tx_skew;
      logic       mirror_en;
      logic       serial_if_en;
   } strap_cfg_t;

   localparam int CFG_W = $bits(strap_cfg_t);

   // one pair's 2-bit index plus polarity flag
   typedef struct packed {
      logic [1:0] phys;
      logic       inv;
   } pair_map_t;

   typedef enum logic [1:0] {
      SPEED_10   = 2'b00,
      SPEED_100  = 2'b01,
      SPEED_1000 = 2'b10
   } speed_t;

   // register map, 16-bit data
   localparam logic [7:0] REG_STRAP_CFG   = 8'h30;  // addr/aneg/skew
   localparam logic [7:0] CONFIG_REG_FOUR = 8'h31;  // mirror/serial if
   localparam logic [7:0] REG_LATCHED     = 8'h32;  // captured codes, read only

   // config_reg_four field positions
   localparam int CONFIG_REG_FOUR_MIRROR_BIT = 0;
   localparam int CONFIG_REG_FOUR_SERIAL_BIT = 1;
   localparam int CONFIG_REG_FOUR_STRAP_CHK  = 7;   // mode-1/2 receive-control strap check enable
   localparam logic [15:0] CONFIG_REG_FOUR_RESET = 16'h0080;

   // strap_cfg register field positions
   localparam int SC_ADDR_LSB = 0;    // [3:0]
   localparam int SC_ANEG_BIT = 4;
   localparam int SC_RXSK_LSB = 5;    // [7:5]
   localparam int SC_TXSK_LSB = 8;    // [9:8]

   localparam strap_mode_t STRAP_DEFAULT = 2'h0;   // mode 1
endpackage : strap_cfg_pkg

/* File: logic/strap_latch_port_mirror.sv */
// strap capture, software-reset reload, register override and mdi mirror map
// assumes strap codes stable while RST_N_I is low; register port one-cycle strobes
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module strap_latch_port_mirror
   import strap_cfg_pkg::*;
(
   // clock and resets
   input  wire logic                      CLOCK_I,
   input  wire logic                      RST_N_I,
   input  wire logic                      SW_RESET_I,
   // strap pins, resolved codes
   input  wire strap_cfg_pkg::strap_pins_t STRAPS_I,
   // register port
   input  wire logic [7:0]                REG_ADDR_I,
   input  wire logic [15:0]               REG_WDATA_I,
   input  wire logic                      REG_WR_I,
   input  wire logic                      REG_RD_I,
   output logic [15:0]                    REG_RDATA_O,
   // datapath context
   input  wire strap_cfg_pkg::speed_t     SPEED_I,
   input  wire logic                      MDIX_I,
   // configuration outputs
   output strap_cfg_pkg::strap_cfg_t      CFG_O,
   output logic                           STRAP_INVALID_O,
   output strap_cfg_pkg::pair_map_t [3:0] PAIR_MAP_O
);
   import strap_cfg_pkg::*;

   strap_pins_t latched;
   logic        in_reset;
   strap_cfg_t  cfg;
   strap_cfg_t  next_cfg;
   logic [15:0] config_reg_four;
   logic        mirror_on;

   // strap codes to configuration record
   function automatic strap_cfg_t decode(input strap_pins_t s);
      strap_cfg_t c;
      c = '0;
      c.mgmt_addr    = {s.addr_high, s.addr_low};
      c.aneg_dis     = (s.rx_ctrl == 2'h3);
      c.rx_skew      = {s.gp1, s.gp0[1]};
      c.tx_skew      = s.tx_skew;
      c.mirror_en    = s.mirror_if[1];
      c.serial_if_en = s.mirror_if[0];
      return c;
   endfunction : decode

   // shared write-address decode for the override and register four paths
   function automatic logic wr_hit(input logic       we,
                                   input logic [7:0] a,
                                   input logic [7:0] target);
      return we && (a == target);
   endfunction : wr_hit

   // capture at power-up/hard reset; a clocked sample while reset is held
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         latched <= STRAPS_I;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      in_reset <= !RST_N_I;
   end

   always_comb begin
      next_cfg = cfg;
      if (wr_hit(REG_WR_I, REG_ADDR_I, REG_STRAP_CFG)) begin
         next_cfg.mgmt_addr = REG_WDATA_I[SC_ADDR_LSB +: 4];
         next_cfg.aneg_dis  = REG_WDATA_I[SC_ANEG_BIT];
         next_cfg.rx_skew   = REG_WDATA_I[SC_RXSK_LSB +: 3];
         next_cfg.tx_skew   = REG_WDATA_I[SC_TXSK_LSB +: 2];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, CONFIG_REG_FOUR)) begin
         next_cfg.mirror_en    = REG_WDATA_I[CONFIG_REG_FOUR_MIRROR_BIT];
         next_cfg.serial_if_en = REG_WDATA_I[CONFIG_REG_FOUR_SERIAL_BIT];
      end
   end

   // live configuration: reset clears, released reset/soft reset reload latch
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         cfg <= '0;
      end else if (in_reset || SW_RESET_I) begin
         cfg <= decode(latched);
      end else begin
         cfg <= next_cfg;
      end
   end

   // bit 7 kept as written; soft reset restores it too
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I || SW_RESET_I) begin
         config_reg_four <= CONFIG_REG_FOUR_RESET;
      end else if (wr_hit(REG_WR_I, REG_ADDR_I, CONFIG_REG_FOUR)) begin
         config_reg_four <= REG_WDATA_I;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         REG_RDATA_O <= 16'h0000;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            REG_STRAP_CFG: REG_RDATA_O <= {6'h00, cfg.tx_skew, cfg.rx_skew,
                                           cfg.aneg_dis, cfg.mgmt_addr};
            CONFIG_REG_FOUR: REG_RDATA_O <= {config_reg_four[15:2], cfg.serial_if_en,
                                             cfg.mirror_en};
            REG_LATCHED: REG_RDATA_O <= {2'h0, latched};
            default: REG_RDATA_O <= 16'h0000;
         endcase
      end else begin
         REG_RDATA_O <= 16'h0000;
      end
   end

   assign CFG_O = cfg;
   // modes 1/2 on receive-control strap undefined while the check is on
   assign STRAP_INVALID_O = config_reg_four[CONFIG_REG_FOUR_STRAP_CHK] && !latched.rx_ctrl[1];

   assign mirror_on = cfg.mirror_en;

   // logical pair index 0..3 = A..D
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         PAIR_MAP_O[p].phys = 2'(p);
         PAIR_MAP_O[p].inv  = 1'b0;
      end
      if (mirror_on) begin
         if (SPEED_I == SPEED_1000) begin
            for (int p = 0; p < 4; p++) begin
               PAIR_MAP_O[p].phys = 2'(3 - p);
               PAIR_MAP_O[p].inv  = 1'b1;
            end
         end else begin
            // only A and B carry signal below gigabit, mdi or mdix alike
            PAIR_MAP_O[0].phys = 2'h3;
            PAIR_MAP_O[1].phys = 2'h2;
            PAIR_MAP_O[0].inv  = 1'b1;
            PAIR_MAP_O[1].inv  = 1'b1;
         end
      end
   end

   // assertions
   sequence released_s;
      !RST_N_I ##1 RST_N_I;
   endsequence

   reload_after_reset_a: assert property (@(posedge CLOCK_I)
      released_s |=> (cfg == decode(latched)))
      else $error("config not loaded from straps after reset");

   capture_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      $stable(latched))
      else $error("latched straps changed outside reset");

   soft_reload_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      SW_RESET_I |=> (cfg == decode(latched)))
      else $error("soft reset did not reload captured straps");

   addr_decode_a: assert property (@(posedge CLOCK_I)
      released_s |=> (cfg.mgmt_addr == {latched.addr_high, latched.addr_low}))
      else $error("management address not taken from straps");

   reg_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (REG_WR_I && REG_ADDR_I == REG_STRAP_CFG && !SW_RESET_I && !in_reset)
      |=> (cfg.mgmt_addr == $past(REG_WDATA_I[3:0])))
      else $error("address write not applied");

   mirror_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (REG_WR_I && REG_ADDR_I == CONFIG_REG_FOUR && !SW_RESET_I && !in_reset)
      |=> (cfg.mirror_en == $past(REG_WDATA_I[0])))
      else $error("mirror enable write not applied");

   gig_swap_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (mirror_on && SPEED_I == SPEED_1000) |->
      (PAIR_MAP_O[0].phys == 2'h3 && PAIR_MAP_O[2].phys == 2'h1 && PAIR_MAP_O[3].inv))
      else $error("gigabit mirror map wrong");

   low_speed_map_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (mirror_on && SPEED_I != SPEED_1000) |->
      (PAIR_MAP_O[0].phys == 2'h3 && PAIR_MAP_O[1].phys == 2'h2 && PAIR_MAP_O[1].inv))
      else $error("10/100 mirror map wrong");

   no_mirror_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !mirror_on |-> (PAIR_MAP_O[2].phys == 2'h2 && !PAIR_MAP_O[0].inv))
      else $error("map altered without mirror");

   read_back_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (REG_RD_I && REG_ADDR_I == REG_LATCHED) |=> (REG_RDATA_O[13:0] == latched))
      else $error("latched codes read back wrong");

   // reload steps: a soft pulse outside reset, and a cycle with nothing to apply
   sequence soft_pulse_s;
      RST_N_I && SW_RESET_I;
   endsequence

   sequence quiet_s;
      RST_N_I && !SW_RESET_I && !in_reset && !REG_WR_I;
   endsequence

   cfg_cleared_a: assert property (@(posedge CLOCK_I)
      !RST_N_I |=> (cfg == '0))
      else $error("config not cleared in reset");

   config_reg_four_restore_a: assert property (@(posedge CLOCK_I)
      (!RST_N_I || SW_RESET_I) |=> (config_reg_four == CONFIG_REG_FOUR_RESET))
      else $error("register four not restored");

   soft_addr_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      soft_pulse_s |=> (cfg.mgmt_addr == {latched.addr_high, latched.addr_low}))
      else $error("soft reset lost strap address");

   rx_skew_a: assert property (@(posedge CLOCK_I)
      released_s |=> (cfg.rx_skew == {latched.gp1, latched.gp0[1]}))
      else $error("receive skew not taken from straps");

   tx_skew_a: assert property (@(posedge CLOCK_I)
      released_s |=> (cfg.tx_skew == latched.tx_skew))
      else $error("transmit skew not taken from straps");

   aneg_strap_a: assert property (@(posedge CLOCK_I)
      released_s |=> (cfg.aneg_dis == (latched.rx_ctrl == 2'h3)))
      else $error("autoneg disable not taken from strap");

   mirror_strap_a: assert property (@(posedge CLOCK_I)
      released_s |=> ({cfg.mirror_en, cfg.serial_if_en} == latched.mirror_if))
      else $error("mirror and interface bits not taken from strap");

   cfg_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      quiet_s |=> $stable(cfg))
      else $error("config changed with no write or reload");

   config_reg_four_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (REG_WR_I && REG_ADDR_I == CONFIG_REG_FOUR && !SW_RESET_I)
      |=> (config_reg_four == $past(REG_WDATA_I)))
      else $error("register four write not stored");

   rdata_idle_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !REG_RD_I |=> (REG_RDATA_O == 16'h0000))
      else $error("read data outside its cycle");

   read_cfg_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (REG_RD_I && REG_ADDR_I == REG_STRAP_CFG) |=> (REG_RDATA_O[3:0] == $past(cfg.mgmt_addr)))
      else $error("address read back wrong");

   invalid_flag_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (config_reg_four[CONFIG_REG_FOUR_STRAP_CHK] && latched.rx_ctrl == 2'h0) |-> STRAP_INVALID_O)
      else $error("mode 1 receive-control strap not flagged");

   gig_rest_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (mirror_on && SPEED_I == SPEED_1000) |-> (PAIR_MAP_O[1].phys == 2'h2 &&
      PAIR_MAP_O[3].phys == 2'h0 && PAIR_MAP_O[0].inv && PAIR_MAP_O[2].inv))
      else $error("gigabit mirror swap incomplete");

   low_speed_cd_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (mirror_on && SPEED_I != SPEED_1000) |-> (PAIR_MAP_O[2].phys == 2'h2 &&
      PAIR_MAP_O[3].phys == 2'h3 && !PAIR_MAP_O[3].inv && PAIR_MAP_O[0].inv))
      else $error("10/100 mirror touched unused pairs");

   // mdi or mdix must not move any pair
   mdix_blind_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      ($changed(MDIX_I) && $stable(SPEED_I) && $stable(mirror_on)) |-> $stable(PAIR_MAP_O))
      else $error("pair map follows crossover");

   // identity, no inversion: D, C, B, A from the top
   identity_map_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !mirror_on |-> (PAIR_MAP_O == 12'hD10))
      else $error("pair map not identity without mirror");
endmodule : strap_latch_port_mirror
`default_nettype wire

/* File: verif/strap_board_model.sv */
// board strap resistors: codes picked from a seed
// assumes the bench changes SEED_I only where a reset or reload test wants it
`timescale 1ns/100ps
`default_nettype none
module strap_board_model
   import strap_cfg_pkg::*;
(
   // resistor choice
   input  wire logic [15:0]           SEED_I,
   // strap codes and host hint
   output strap_cfg_pkg::strap_pins_t STRAPS_O,
   output logic                       CONFIG_REG_FOUR_CLEAR_O
);
   import strap_cfg_pkg::*;

   always_comb begin
      STRAPS_O     = SEED_I[13:0];
      // only modes 1 and 3 are fitted on this pin
      STRAPS_O.gp0 = {SEED_I[7], 1'b0};
      CONFIG_REG_FOUR_CLEAR_O = (STRAPS_O.rx_ctrl < 2'h2);
   end
endmodule : strap_board_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench: random straps, register overrides, reload, mirror map
// assumes the register port answers reads one cycle later
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import strap_cfg_pkg::*;
   logic             clk, rst_n, sw_rst, wr, rd, mdix, invalid, need_clr;
   logic [7:0]       addr;
   logic [15:0]      wdata, rdata, seed, lfsr, d;
   speed_t           speed;
   strap_pins_t      straps, held;
   strap_cfg_t       cfg;
   pair_map_t [3:0]  pmap;
   int               bad_count, comparisons;

   strap_board_model board (.SEED_I(seed), .STRAPS_O(straps), .CONFIG_REG_FOUR_CLEAR_O(need_clr));
   strap_latch_port_mirror DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .SW_RESET_I(sw_rst),
      .STRAPS_I(straps), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
      .REG_RD_I(rd), .REG_RDATA_O(rdata), .SPEED_I(speed), .MDIX_I(mdix),
      .CFG_O(cfg), .STRAP_INVALID_O(invalid), .PAIR_MAP_O(pmap));

   always #10 clk = ~clk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   function automatic strap_cfg_t exp_cfg(input strap_pins_t s);
      return {s.addr_high, s.addr_low, s.rx_ctrl == 2'h3, s.gp1, s.gp0[1], s.tx_skew,
              s.mirror_if};
   endfunction : exp_cfg
   // register four after a reload: reset word with the strap mirror/interface bits
   function automatic logic [15:0] exp_config_reg_four(input strap_pins_t s);
      return {CONFIG_REG_FOUR_RESET[15:2], s.mirror_if[0], s.mirror_if[1]};
   endfunction : exp_config_reg_four
   function automatic logic [15:0] exp_ovr(input logic [15:0] v);
      return {6'h00, v[3:0], v[4], v[7:5], v[9:8]};
   endfunction : exp_ovr
   function automatic logic [11:0] exp_map(input speed_t sp, input logic mir);
      pair_map_t [3:0] m;
      for (int p = 0; p < 4; p++) begin
         m[p] = {2'(p), 1'b0};
         if (mir && (sp == SPEED_1000 || p < 2)) begin
            m[p] = {2'(3 - p), 1'b1};
         end
      end
      return m;
   endfunction : exp_map

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_word
   task automatic chk_map(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: pair map got %h exp %h", $time, got, exp);
      end
   endtask : chk_map
   task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : reg_rd
   task automatic hw_reset(input logic [15:0] s);
      @(posedge clk);
      rst_n <= 1'b0;
      seed <= s;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // first edge after release reloads, requests from the second
      repeat (2) @(posedge clk);
      #1;
   endtask : hw_reset
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      {clk, rst_n, sw_rst, wr, rd, mdix} = '0;
      {addr, wdata, seed} = '0;
      speed = SPEED_10;
      lfsr = 16'h0003;
      bad_count = 0;
      comparisons = 0;
      for (int i = 0; i < 5; i++) begin
         lfsr = lfsr_next(lfsr);
         hw_reset(i == 0 ? 16'h0000 : (i == 1 ? 16'hFFFF : lfsr));
         held = straps;
         chk_word(16'(cfg), 16'(exp_cfg(held)), "strap decode");
         chk_word(16'(cfg), 16'(exp_cfg(held)), "strap fields");
         chk_map(pmap, exp_map(speed, held.mirror_if[1]));
         reg_rd(REG_LATCHED, d);
         chk_word(d, {2'b00, held}, "latched codes");
         reg_rd(CONFIG_REG_FOUR, d);
         chk_word(d, exp_config_reg_four(held), "config_reg_four reset");
         chk_word(16'(invalid), 16'(need_clr), "strap check");
         reg_wr(CONFIG_REG_FOUR, 16'h0000);
         chk_word(16'(invalid), 16'h0000, "check cleared");
      end
      $display("test strap capture done");
      lfsr = lfsr_next(lfsr);
      reg_wr(REG_STRAP_CFG, lfsr);
      chk_word(16'(cfg[11:2]), exp_ovr(lfsr), "override");
      reg_rd(REG_STRAP_CFG, d);
      chk_word(d, {6'h00, lfsr[9:0]}, "override readback");
      @(posedge clk);
      #1;
      chk_word(rdata, 16'h0000, "read data one cycle only");
      reg_wr(8'h00, 16'hFFFF);
      chk_word(16'(cfg[11:2]), exp_ovr(lfsr), "unmapped");
      reg_rd(8'h00, d);
      chk_word(d, 16'h0000, "unmapped read");
      @(posedge clk);
      seed <= ~seed;
      sw_rst <= 1'b1;
      @(posedge clk);
      sw_rst <= 1'b0;
      #1;
      chk_word(16'(cfg), 16'(exp_cfg(held)), "soft reload");
      reg_rd(CONFIG_REG_FOUR, d);
      chk_word(d, exp_config_reg_four(held), "config_reg_four reload");
      reg_rd(REG_LATCHED, d);
      chk_word(d, {2'b00, held}, "no resample");
      $display("test override and reload done");
      // speed holds for two steps so a crossover flip alone is seen too
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         speed <= speed_t'((k / 2) % 3);
         mdix <= k[0];
         reg_wr(CONFIG_REG_FOUR, {15'h0000, k[2]});
         chk_map(pmap, exp_map(speed_t'((k / 2) % 3), k[2]));
      end
      $display("test mirror map done");
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
